// ==== bus_access_consts.vh ====
// constants for the cpu memory bus access unit
`ifndef BUS_ACCESS_CONSTS_VH
`define BUS_ACCESS_CONSTS_VH

// ************************************************************
// access size codes
// ************************************************************
`define SZ_8 2'h0
`define SZ_16 2'h1
`define SZ_32 2'h2

// ************************************************************
// region codes and device widths
// ************************************************************
`define RG_IRAM 3'h0
`define RG_PERI 3'h1
`define RG_DDRAM 3'h2
`define RG_FLASH 3'h3
`define RG_NONE 3'h4
`define DW_8 2'h0
`define DW_16 2'h1
`define DW_32 2'h2

// ************************************************************
// address map, 24-bit space
// ************************************************************
`define IRAM_BASE 24'h000000
`define IRAM_END 24'h003FFF
`define PERI_BASE 24'h004000
`define PERI_END 24'h005FFF
`define DDRAM_BASE 24'h006000
`define DDRAM_END 24'h007FFF
`define FLASH_BASE 24'h008000
`define FLASH_END 24'h0FFFFF

// ************************************************************
// reset values and fields
// ************************************************************
`define VEC_BASE_RST 24'h008000
`define REG_DATA_MSB 23
`define PSW_LSB 24
`define UPPER_ZERO 8'h00
`define FWAIT_RST 2'h0

`endif

// ==== region_decoder.v ====
// address region and device width decoder
`timescale 1ns/100ps
module region_decoder (
   // address in
   input wire [23:0] addr_i,
   // decode out
   output reg [2:0] region_o,
   output reg [1:0] dev_width_o
);
`include "bus_access_consts.vh"

   // full 24-bit compare so every alias outside the map lands in none
   always @* begin
      if (addr_i <= `IRAM_END) begin
         region_o = `RG_IRAM;
         dev_width_o = `DW_32;
      end else if (addr_i >= `PERI_BASE && addr_i <= `PERI_END) begin
         region_o = `RG_PERI;
         dev_width_o = `DW_16;
      end else if (addr_i >= `DDRAM_BASE && addr_i <= `DDRAM_END) begin
         region_o = `RG_DDRAM;
         dev_width_o = `DW_16;
      end else if (addr_i >= `FLASH_BASE && addr_i <= `FLASH_END) begin
         region_o = `RG_FLASH;
         dev_width_o = `DW_16;
      end else begin
         region_o = `RG_NONE;
         dev_width_o = `DW_8;
      end
   end
endmodule // region_decoder

// ==== bus_access_unit.v ====
// cpu memory bus access unit: splitting, stalls, conflicts
`timescale 1ns/100ps
module bus_access_unit (
   // clock and reset
   input wire core_clk_i,
   input wire resetn_i,
   // instruction fetch master
   input wire if_req_i,
   input wire [23:0] if_addr_i,
   output wire if_ready_o,
   output reg [15:0] if_rdata_o,
   // data master
   input wire d_req_i,
   input wire [23:0] d_addr_i,
   input wire [1:0] d_size_i,
   input wire d_we_i,
   input wire d_stack_i,
   input wire [23:0] d_wdata_i,
   input wire [7:0] processor_status_word_i,
   output wire d_busy_o,
   output reg d_done_o,
   output reg [23:0] d_rdata_o,
   output reg [7:0] processor_status_word_o,
   // vector table
   input wire vec_base_load_i,
   input wire [23:0] vec_base_i,
   input wire [7:0] vec_num_i,
   output reg [23:0] vec_addr_o,
   // flash wait control
   input wire [1:0] flash_read_wait_select_i,
   // instruction memory port
   output wire im_req_o,
   output wire [23:0] im_addr_o,
   input wire [15:0] im_rdata_i,
   // data memory port
   output reg dm_req_o,
   output reg dm_we_o,
   output reg [23:0] dm_addr_o,
   output reg [1:0] dm_size_o,
   output reg [31:0] dm_wdata_o,
   input wire [31:0] dm_rdata_i
);
`include "bus_access_consts.vh"

   // ************************************************************
   // states and helpers
   // ************************************************************
   localparam ST_IDLE = 2'h0;
   localparam ST_BEAT = 2'h1;
   localparam ST_WAIT = 2'h2;

   // beats per access from device width and access size
   function [2:0] beat_count;
      input [1:0] dw;
      input [1:0] sz;
      if (dw == `DW_32 || sz == `SZ_8)
         beat_count = 3'h1;
      else if (dw == `DW_16)
         beat_count = (sz == `SZ_32) ? 3'h2 : 3'h1;
      else
         beat_count = (sz == `SZ_32) ? 3'h4 : 3'h2;
   endfunction

   // size of one beat: the narrower of device and access
   function [1:0] beat_size;
      input [1:0] dw;
      input [1:0] sz;
      beat_size = (dw < sz) ? dw : sz;
   endfunction

   // conflict table between fetch region and data region
   function conflict;
      input [2:0] fr;
      input [2:0] dr;
      reg f_ram;
      reg d_ram;
      begin
         f_ram = (fr == `RG_IRAM) || (fr == `RG_DDRAM);
         d_ram = (dr == `RG_IRAM) || (dr == `RG_DDRAM);
         conflict = 1'b0;
         if (fr == `RG_FLASH && dr == `RG_FLASH)
            conflict = 1'b1;
         if (fr == `RG_FLASH && dr == `RG_DDRAM)
            conflict = 1'b1;
         if (f_ram && d_ram)
            conflict = 1'b1;
      end
   endfunction

   // ************************************************************
   // decoders
   // ************************************************************
   wire [2:0] f_region;
   wire [1:0] f_width;
   wire [2:0] d_region;
   wire [1:0] d_width;

   region_decoder u_fetch_dec (
      .addr_i(if_addr_i),
      .region_o(f_region),
      .dev_width_o(f_width)
   );

   region_decoder u_data_dec (
      .addr_i(d_addr_i),
      .region_o(d_region),
      .dev_width_o(d_width)
   );

   // ************************************************************
   // data access state
   // ************************************************************
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [2:0] region_ff;
   reg [23:0] addr_ff;
   reg [1:0] size_ff;
   reg [1:0] bsize_ff;
   reg we_ff;
   reg stack_ff;
   reg [31:0] wbuf_ff;
   reg [31:0] rbuf_ff;
   reg [2:0] beats_left_ff;
   reg [2:0] beat_idx_ff;
   reg [1:0] wait_ff;
   reg [1:0] wait_set_ff;
   reg [1:0] fwait_ff;

   wire take = (state_ff == ST_IDLE) && d_req_i;
   wire last_beat = (beats_left_ff == 3'h1);
   wire beat_now = (state_ff == ST_BEAT);
   // master held until the last part is done
   assign d_busy_o = (state_ff != ST_IDLE);

   // wait setting latched so mid-access changes cannot stretch one beat
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fwait_ff <= `FWAIT_RST;
      end else begin
         fwait_ff <= flash_read_wait_select_i;
      end
   end

   // next state; each beat one system clock plus wait_set_ff wait cycles
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:
            if (d_req_i)
               nxt_state = ST_BEAT;
         ST_BEAT:
            if (wait_set_ff != 2'h0)
               nxt_state = ST_WAIT;
            else if (last_beat)
               nxt_state = ST_IDLE;
         ST_WAIT:
            if (wait_ff == 2'h1)
               nxt_state = last_beat ? ST_IDLE : ST_BEAT;
         default: nxt_state = ST_IDLE;
      endcase
   end

   // write image; stack frames carry the status byte on top
   reg [31:0] wimage;
   always @* begin
      wimage = {`UPPER_ZERO, d_wdata_i};
      if (d_stack_i)
         wimage = {processor_status_word_i, d_wdata_i};
   end

   // data beat sequencing
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_ff <= ST_IDLE;
         region_ff <= `RG_NONE;
         addr_ff <= 24'h000000;
         size_ff <= `SZ_8;
         bsize_ff <= `SZ_8;
         we_ff <= 1'b0;
         stack_ff <= 1'b0;
         wbuf_ff <= 32'h00000000;
         rbuf_ff <= 32'h00000000;
         beats_left_ff <= 3'h0;
         beat_idx_ff <= 3'h0;
         wait_ff <= 2'h0;
         wait_set_ff <= 2'h0;
      end else begin
         state_ff <= nxt_state;
         if (take) begin
            region_ff <= d_region;
            addr_ff <= d_addr_i;
            size_ff <= d_size_i;
            bsize_ff <= beat_size(d_width, d_size_i);
            we_ff <= d_we_i;
            stack_ff <= d_stack_i;
            wbuf_ff <= wimage;
            rbuf_ff <= 32'h00000000;
            beats_left_ff <= beat_count(d_width, d_size_i);
            beat_idx_ff <= 3'h0;
            // waits only on flash reads
            wait_set_ff <= (d_region == `RG_FLASH && !d_we_i) ? fwait_ff : 2'h0;
            wait_ff <= (d_region == `RG_FLASH && !d_we_i) ? fwait_ff : 2'h0;
         end
         // read data sampled in the beat, or in the last wait cycle
         if ((beat_now && wait_set_ff == 2'h0) || (state_ff == ST_WAIT && wait_ff == 2'h1)) begin
            case (bsize_ff)
               `SZ_8: rbuf_ff[{beat_idx_ff[1:0], 3'h0} +: 8] <= dm_rdata_i[7:0];
               `SZ_16: rbuf_ff[{beat_idx_ff[0], 4'h0} +: 16] <= dm_rdata_i[15:0];
               default: rbuf_ff <= dm_rdata_i;
            endcase
            beats_left_ff <= beats_left_ff - 3'h1;
            beat_idx_ff <= beat_idx_ff + 3'h1;
            wait_ff <= wait_set_ff;
         end else if (state_ff == ST_WAIT) begin
            wait_ff <= wait_ff - 2'h1;
         end
      end
   end

   // ************************************************************
   // data memory port, low address part first
   // ************************************************************
   reg [23:0] beat_off;
   always @* begin
      case (bsize_ff)
         `SZ_8: beat_off = {21'h000000, beat_idx_ff};
         `SZ_16: beat_off = {20'h00000, beat_idx_ff, 1'b0};
         default: beat_off = 24'h000000;
      endcase
   end

   // drive each beat with its slice of the write image
   always @* begin
      dm_req_o = beat_now;
      dm_we_o = beat_now && we_ff;
      dm_addr_o = addr_ff + beat_off;
      dm_size_o = bsize_ff;
      case (bsize_ff)
         `SZ_8: dm_wdata_o = {24'h000000, wbuf_ff[{beat_idx_ff[1:0], 3'h0} +: 8]};
         `SZ_16: dm_wdata_o = {16'h0000, wbuf_ff[{beat_idx_ff[0], 4'h0} +: 16]};
         default: dm_wdata_o = wbuf_ff;
      endcase
   end

   // ************************************************************
   // completion to the data master
   // ************************************************************
   wire finishing = d_busy_o && (nxt_state == ST_IDLE);

   // last slice merged before the 24-bit cut
   reg [31:0] rmerge;
   always @* begin
      rmerge = rbuf_ff;
      case (bsize_ff)
         `SZ_8: rmerge[{beat_idx_ff[1:0], 3'h0} +: 8] = dm_rdata_i[7:0];
         `SZ_16: rmerge[{beat_idx_ff[0], 4'h0} +: 16] = dm_rdata_i[15:0];
         default: rmerge = dm_rdata_i;
      endcase
   end

   // result registered one cycle after the last beat or wait
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         d_done_o <= 1'b0;
         d_rdata_o <= 24'h000000;
         processor_status_word_o <= 8'h00;
      end else begin
         d_done_o <= finishing;
         if (finishing && !we_ff) begin
            // upper byte dropped for registers
            d_rdata_o <= rmerge[`REG_DATA_MSB:0];
            if (stack_ff && size_ff == `SZ_32)
               processor_status_word_o <= rmerge[31:`PSW_LSB];
         end
      end
   end

   // ************************************************************
   // instruction fetch path
   // ************************************************************
   // stall covers beats and flash waits alike
   wire fetch_stall = d_busy_o && conflict(f_region, region_ff);
   // parallel with data unless both are in ram, both in flash, or fetch is in flash with data in ddram
   assign im_req_o = if_req_i && !fetch_stall;
   assign im_addr_o = if_addr_i;
   assign if_ready_o = im_req_o;

   // fetched word registered for the core
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         if_rdata_o <= 16'h0000;
      end else if (im_req_o) begin
         if_rdata_o <= im_rdata_i;
      end
   end

   // ************************************************************
   // vector table base
   // ************************************************************
   reg [23:0] vec_base_ff;
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         vec_base_ff <= `VEC_BASE_RST;
      end else if (vec_base_load_i) begin
         vec_base_ff <= vec_base_i;
      end
   end

   // four bytes per entry, offset from the base
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         vec_addr_o <= `VEC_BASE_RST;
      end else begin
         vec_addr_o <= vec_base_ff + {14'h0000, vec_num_i, 2'h0};
      end
   end
endmodule // bus_access_unit

// ==== bus_access_unit_chk.sv ====
// port-level assertions for the bus access unit
`timescale 1ns/100ps
`include "bus_access_consts.vh"
module bus_access_unit_chk (
   // clock and reset
   input wire core_clk_i,
   input wire resetn_i,
   // fetch side
   input wire if_req_i,
   input wire [23:0] if_addr_i,
   input wire if_ready_o,
   input wire [15:0] if_rdata_o,
   input wire im_req_o,
   input wire [23:0] im_addr_o,
   input wire [15:0] im_rdata_i,
   // data side
   input wire d_req_i,
   input wire [23:0] d_addr_i,
   input wire [1:0] d_size_i,
   input wire d_we_i,
   input wire d_stack_i,
   input wire [23:0] d_wdata_i,
   input wire [7:0] processor_status_word_i,
   input wire d_busy_o,
   input wire d_done_o,
   input wire dm_req_o,
   input wire [23:0] dm_addr_o,
   input wire [1:0] dm_size_o,
   input wire [31:0] dm_wdata_o
);
   // ************************************************************
   // region helpers
   // ************************************************************
   function automatic fl(input [23:0] a);
      fl = a >= `FLASH_BASE && a <= `FLASH_END;
   endfunction
   function automatic rd(input [23:0] a);
      rd = a <= `IRAM_END || (a >= `DDRAM_BASE && a <= `DDRAM_END);
   endfunction
   wire take = d_req_i & ~d_busy_o;
   wire conf_w = (fl(if_addr_i) && (fl(dm_addr_o) || (dm_addr_o >= `DDRAM_BASE && dm_addr_o <= `DDRAM_END)))
      || (rd(if_addr_i) && rd(dm_addr_o));
   reg [23:0] t_addr_ff;
   // keep the taken address so later beats can be judged against it
   always @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) t_addr_ff <= 24'h000000;
      else if (take) t_addr_ff <= d_addr_i;
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   sequence first_half;
      dm_req_o && dm_size_o == `SZ_16 && dm_addr_o == t_addr_ff;
   endsequence
   sequence second_half;
      dm_req_o && dm_addr_o == t_addr_ff + 24'h000002;
   endsequence
   chk_fetch_parallel: assert property (if_req_i && (!d_busy_o || !conf_w) |-> if_ready_o)
      else $error("fetch stalled without conflict");
   chk_fetch_stall: assert property (if_req_i && d_busy_o && conf_w |-> !if_ready_o)
      else $error("fetch ran during conflicting data access");
   chk_fetch_port: assert property (if_ready_o |-> im_req_o && im_addr_o == if_addr_i)
      else $error("fetch address not passed to memory");
   chk_fetch_data: assert property (if_ready_o |=> if_rdata_o == $past(im_rdata_i))
      else $error("fetch data not captured");
   chk_done_pulse: assert property (d_done_o |-> !d_busy_o ##1 !d_done_o)
      else $error("done not a single pulse");
   chk_word_single: assert property (take && d_addr_i <= `IRAM_END |=> dm_req_o ##1 d_done_o)
      else $error("word device access not one cycle");
   chk_half_single: assert property (take && d_size_i == `SZ_16 && d_addr_i <= `FLASH_END
      && (d_we_i || !fl(d_addr_i)) |=> dm_req_o ##1 d_done_o)
      else $error("16-bit access not one cycle");
   chk_peri_split: assert property (take && d_size_i == `SZ_32 && d_addr_i >= `PERI_BASE
      && d_addr_i <= `PERI_END |=> first_half ##1 second_half ##1 d_done_o)
      else $error("peripheral 32-bit split wrong");
   chk_write_zero: assert property (take && d_we_i && !d_stack_i && d_size_i == `SZ_32 && d_addr_i <= `IRAM_END
      |=> dm_wdata_o == {`UPPER_ZERO, $past(d_wdata_i)})
      else $error("upper write byte not zero");
   chk_stack_push: assert property (take && d_we_i && d_stack_i && d_size_i == `SZ_32 && d_addr_i <= `IRAM_END
      |=> dm_wdata_o == {$past(processor_status_word_i), $past(d_wdata_i)})
      else $error("stack frame layout wrong");
endmodule // bus_access_unit_chk

// ==== bus_access_mem_model.sv ====
// behavioural memories answering the fetch and data ports
`timescale 1ns/100ps
module bus_access_mem_model (
   // instruction port
   input wire fetch_req_i,
   input wire [23:0] fetch_addr_i,
   output wire [15:0] fetch_data_o,
   // data port
   input wire [23:0] data_addr_i,
   output wire [31:0] data_rdata_o
);
   function automatic [7:0] mb(input [23:0] a);
      mb = a[7:0] ^ a[15:8] ^ 8'hA5;
   endfunction
   // idle fetch port shows a moving pattern so stale data never matches
   assign fetch_data_o = fetch_req_i ? {mb(fetch_addr_i + 24'h1), mb(fetch_addr_i)} : ~fetch_addr_i[15:0];
   // little-endian slice, lowest address in the low byte
   assign data_rdata_o = {mb(data_addr_i + 24'h3), mb(data_addr_i + 24'h2), mb(data_addr_i + 24'h1), mb(data_addr_i)};
endmodule // bus_access_mem_model

// ==== cpu_memory_bus_access_unit_tb_top.sv ====
// self-checking testbench for the bus access unit
`timescale 1ns/100ps
`include "bus_access_consts.vh"
module cpu_memory_bus_access_unit_tb_top;
   logic core_clk_i, resetn_i, if_req_i, d_req_i, d_we_i, d_stack_i, vec_base_load_i, fetch_on, fetch_taken;
   logic [23:0] if_addr_i, d_addr_i, d_wdata_i, vec_base_i, d_rdata_o, vec_addr_o, im_addr_o, dm_addr_o;
   logic [1:0] d_size_i, flash_read_wait_select_i, dm_size_o;
   logic [7:0] processor_status_word_i, vec_num_i, processor_status_word_o;
   logic [15:0] im_rdata_i, if_rdata_o;
   logic [31:0] dm_rdata_i, dm_wdata_o;
   logic if_ready_o, d_busy_o, d_done_o, im_req_o, dm_req_o, dm_we_o;
   int errors, check_count, cyc, i, seed_v;
   bus_access_unit i_bus_access_unit (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .if_req_i(if_req_i),
      .if_addr_i(if_addr_i), .if_ready_o(if_ready_o), .if_rdata_o(if_rdata_o), .d_req_i(d_req_i),
      .d_addr_i(d_addr_i), .d_size_i(d_size_i), .d_we_i(d_we_i), .d_stack_i(d_stack_i), .d_wdata_i(d_wdata_i),
      .processor_status_word_i(processor_status_word_i), .d_busy_o(d_busy_o), .d_done_o(d_done_o),
      .d_rdata_o(d_rdata_o), .processor_status_word_o(processor_status_word_o), .vec_base_load_i(vec_base_load_i),
      .vec_base_i(vec_base_i), .vec_num_i(vec_num_i), .vec_addr_o(vec_addr_o),
      .flash_read_wait_select_i(flash_read_wait_select_i), .im_req_o(im_req_o), .im_addr_o(im_addr_o),
      .im_rdata_i(im_rdata_i), .dm_req_o(dm_req_o), .dm_we_o(dm_we_o), .dm_addr_o(dm_addr_o),
      .dm_size_o(dm_size_o), .dm_wdata_o(dm_wdata_o), .dm_rdata_i(dm_rdata_i));
   bus_access_mem_model i_bus_access_mem_model (.fetch_req_i(im_req_o), .fetch_addr_i(im_addr_o),
      .fetch_data_o(im_rdata_i), .data_addr_i(dm_addr_o), .data_rdata_o(dm_rdata_i));
   // ************************************************************
   // expectations
   // ************************************************************
   function automatic [7:0] mb(input [23:0] a);
      mb = a[7:0] ^ a[15:8] ^ 8'hA5;
   endfunction
   function automatic int ncyc(input [23:0] a, input [1:0] sz, input logic we, input [1:0] w);
      int b;
      if (a <= `IRAM_END) b = 1;
      else if (a <= `FLASH_END) b = (sz == `SZ_32) ? 2 : 1;
      else b = 1 << sz;
      ncyc = 1 + b * (1 + ((a >= `FLASH_BASE && a <= `FLASH_END && !we) ? w : 0));
   endfunction
   function automatic [23:0] pick(input int unsigned r);
      logic [23:0] base [5] = '{24'h000100, 24'h004000, 24'h006000, 24'h008000, 24'h100000};
      pick = base[r % 5] + ($urandom & 24'h000FFC);
   endfunction
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task results;
      if (errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // one data access, entered at a falling edge while the unit is free
   task automatic dacc(input [23:0] a, input [1:0] sz, input logic we, input logic st);
      int k;
      logic [31:0] wd;
      logic [23:0] m;
      d_addr_i = a;
      d_size_i = sz;
      d_we_i = we;
      d_stack_i = st && sz == `SZ_32;
      d_wdata_i = $urandom;
      processor_status_word_i = $urandom;
      d_req_i = 1'b1;
      @(negedge core_clk_i);
      d_req_i = 1'b0;
      // take cycle counts as cycle 1; first beat stands now
      k = 1;
      wd = dm_wdata_o;
      chk("strobe", {1'b1, we}, {dm_req_o, dm_we_o});
      while (d_done_o !== 1'b1 && k < 60) begin
         @(negedge core_clk_i);
         k++;
      end
      chk("cycles", ncyc(a, sz, we, flash_read_wait_select_i), k);
      m = sz == `SZ_32 ? 24'hFFFFFF : sz == `SZ_16 ? 24'h00FFFF : 24'h0000FF;
      if (!we) chk("rdata", {mb(a + 24'h2), mb(a + 24'h1), mb(a)} & m, d_rdata_o & m);
      if (!we && d_stack_i) chk("status", mb(a + 24'h3), processor_status_word_o);
      if (we && sz == `SZ_32 && a <= `IRAM_END)
         chk("wdata", {d_stack_i ? processor_status_word_i : `UPPER_ZERO, d_wdata_i}, wd);
   endtask
   // ************************************************************
   // clock, fetch master and watchdog
   // ************************************************************
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   // fetch request held until the unit takes it
   always @(posedge core_clk_i) fetch_taken <= if_req_i & if_ready_o;
   always @(negedge core_clk_i) begin
      if (fetch_on && (!if_req_i || fetch_taken)) begin
         if_req_i = $urandom;
         if_addr_i = pick($urandom) & 24'hFFFFFE;
      end
   end
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         results();
      end
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      errors = 0;
      check_count = 0;
      cyc = 0;
      fetch_on = 0;
      fetch_taken = 0;
      seed_v = $urandom(2);
      {resetn_i, if_req_i, d_req_i, d_we_i, d_stack_i, vec_base_load_i} = 6'h00;
      {if_addr_i, d_addr_i, d_wdata_i, vec_base_i} = 96'h0;
      {d_size_i, flash_read_wait_select_i, processor_status_word_i} = 12'h000;
      vec_num_i = $urandom;
      repeat (8) @(negedge core_clk_i);
      resetn_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      chk("vector", `VEC_BASE_RST + 4 * vec_num_i, vec_addr_o);
      vec_base_i = $urandom & 24'hFFFFFC;
      vec_base_load_i = 1'b1;
      @(negedge core_clk_i);
      vec_base_load_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      chk("vector", 24'(vec_base_i + 4 * vec_num_i), vec_addr_o);
      dacc(24'h004000, `SZ_32, 1'b1, 1'b0);
      dacc(24'h000100, `SZ_32, 1'b1, 1'b1);
      dacc(24'h000100, `SZ_32, 1'b0, 1'b1);
      dacc(24'h100000, `SZ_32, 1'b0, 1'b0);
      fetch_on = 1;
      // back-to-back accesses of every size and region, wait setting changed now and then
      for (i = 0; i < 80; i++) begin
         if (i % 10 == 0) begin
            flash_read_wait_select_i = $urandom;
            @(negedge core_clk_i);
         end
         dacc(pick($urandom), 2'($urandom % 3), 1'($urandom), 1'($urandom));
      end
      results();
   end
endmodule // cpu_memory_bus_access_unit_tb_top
bind bus_access_unit bus_access_unit_chk i_bus_access_unit_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
   .if_req_i(if_req_i), .if_addr_i(if_addr_i), .if_ready_o(if_ready_o), .if_rdata_o(if_rdata_o),
   .im_req_o(im_req_o), .im_addr_o(im_addr_o), .im_rdata_i(im_rdata_i), .d_req_i(d_req_i), .d_addr_i(d_addr_i),
   .d_size_i(d_size_i), .d_we_i(d_we_i), .d_stack_i(d_stack_i), .d_wdata_i(d_wdata_i),
   .processor_status_word_i(processor_status_word_i), .d_busy_o(d_busy_o), .d_done_o(d_done_o),
   .dm_req_o(dm_req_o), .dm_addr_o(dm_addr_o), .dm_size_o(dm_size_o), .dm_wdata_o(dm_wdata_o));
